// [motor_bridge_map.vh]
`ifndef MOTOR_BRIDGE_MAP_VH
`define MOTOR_BRIDGE_MAP_VH
// Serial frame layout
`define FRAME_BITS 16
`define FRAME_CNT_W 5
`define CFG_MODE_BIT 13
`define CFG_DIR_C_BIT 12
`define CFG_DIR_A_BIT 11
`define CFG_DIR_B_BIT 10
`define CFG_HS1_BIT 9
`define CFG_HS2_BIT 8
`define CFG_LS1_BIT 7
`define CFG_LS2_BIT 6
`define CFG_RESET 16'h0000
// Synchroniser preset: supply reads low, reset and enable read released
`define SYNC_RESET 13'h0120
// Timing, ref_clk 10 MHz
`define CLK_HZ 10000000
`define OSC_HZ 200000
`define OSC_DIV (`CLK_HZ / `OSC_HZ)
`define DEGLITCH_NS 500
`define OSC_TICK_NS 5000
`define DEGLITCH_CYCLES ((`DEGLITCH_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define ON_DUTY_PCT 4
`define OFF_TIME_NS 25000
`define OFF_TICKS (`OFF_TIME_NS * (100 - `ON_DUTY_PCT) / (`ON_DUTY_PCT * `OSC_TICK_NS))
`define DEAD_NS 500
`define DEAD_CYCLES ((`DEAD_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`endif

// [motor_bridge_control.v]
`timescale 1ns/10ps
`include "motor_bridge_map.vh"
// Summary of operation
// - Bridge A high-side outputs follow the drive A PWM input level.
// - Bridge B high-side outputs follow the drive B PWM input level.
// - Driver C phase A follows PWM A, phase B follows PWM B.
// - In DC mode the driver C high side picked by direction modulates from PWM A only.
// - Config bit 13 picks mode: 0 step, 1 DC bridge.
// - In DC mode low-side transistors serve as general low-side outputs.
// - In step mode high-side transistors serve as general high-side outputs.
// - Driver C direction and high-side outputs 1 and 2 come from serial bits.
// - Supply above 20 V forces all step outputs off.
// - Direction reversal is applied at once, even with current flowing.
// - Open PWM inputs read low: PWM-driven high sides stay off, step counterphases turn on.
// - Overcurrent acts only after deglitch window, then off-timer starts.
// - Off-timer holds bridge off for about four percent on-duty.
// - Thermal shutdown disables motor bridge outputs.
// - Supervisor reset turns step outputs off and bridge A and B low sides on.
// - Config updates only on a frame's 16th serial bit, and only if that bit is high.
// - Step counterphase turns on only after a dead time.
module motor_bridge_control (
  input wire ref_clk,
  input wire rst,
  input wire drive_a_pwm_in,
  input wire drive_b_pwm_in,
  input wire drive_c_pwm_a_in,
  input wire drive_c_pwm_b_in,
  input wire ser_clk,
  input wire ser_enable_n,
  input wire ser_data_in,
  input wire supply_over_20v,
  input wire supervisor_reset_n,
  input wire thermal_shutdown_flag,
  input wire [2:0] overcurrent,
  output reg [1:0] motor_a_bridge_high,
  output reg [1:0] motor_a_bridge_low,
  output reg [1:0] motor_b_bridge_high,
  output reg [1:0] motor_b_bridge_low,
  output reg drive_c_out_first,
  output reg drive_c_out_second,
  output reg [1:0] drive_c_low,
  output reg [1:0] step_phase_on,
  output reg [1:0] step_counter_on,
  output wire [2:0] bridge_tripped,
  output reg dc_mode
);
  // Counter reloads kept at full width, then cut to each counter
  localparam [31:0] OSC_RELOAD = `OSC_DIV - 1;
  localparam [31:0] GLITCH_LIMIT = `DEGLITCH_CYCLES;
  localparam [31:0] OFF_RELOAD = `OFF_TICKS;
  localparam [31:0] DEAD_RELOAD = `DEAD_CYCLES;
  localparam [12:0] SYNC_PRESET = `SYNC_RESET;

  // Two-flop synchronisers for every pin input
  wire [12:0] raw_pins = {
    overcurrent,
    thermal_shutdown_flag,
    supervisor_reset_n,
    supply_over_20v,
    ser_data_in,
    ser_enable_n,
    ser_clk,
    drive_c_pwm_b_in,
    drive_c_pwm_a_in,
    drive_b_pwm_in,
    drive_a_pwm_in
  };
  wire [12:0] sync2;
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi = gi + 1) begin : g_sync
      reg stage1;
      reg stage2;
      always @(posedge ref_clk) begin
        if (rst) begin
          stage1 <= SYNC_PRESET[gi];
          stage2 <= SYNC_PRESET[gi];
        end else begin
          stage1 <= raw_pins[gi];
          stage2 <= stage1;
        end
      end
      assign sync2[gi] = stage2;
    end
  endgenerate
  // Pads pull low when open, so a floating pin reads as off
  wire pwm_a = sync2[0];
  wire pwm_b = sync2[1];
  wire pwm_ca = sync2[2];
  wire pwm_cb = sync2[3];
  wire s_clk = sync2[4];
  wire s_en_n = sync2[5];
  wire s_data = sync2[6];
  wire over_v = sync2[7];
  wire sup_rst = ~sync2[8];
  wire therm = sync2[9];
  wire [2:0] oc = sync2[12:10];

  // Serial configuration shift register
  reg s_clk_d;
  reg [15:0] shift;
  reg [`FRAME_CNT_W-1:0] bit_cnt;
  reg [15:0] cfg;
  wire s_rise = s_clk & ~s_clk_d;
  wire [15:0] next_shift = {shift[14:0], s_data};
  // Last-bit test sits on the 16th rise, so short frames never land
  wire frame_done = s_rise && !s_en_n && (bit_cnt == 5'h0F) && s_data;

  always @(posedge ref_clk) begin
    if (rst || sup_rst) begin
      s_clk_d <= 1'b0;
    end else begin
      s_clk_d <= s_clk;
    end
  end

  always @(posedge ref_clk) begin
    if (rst || sup_rst) begin
      shift <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (s_en_n) begin
      bit_cnt <= 5'h00;
    end else if (s_rise) begin
      shift <= next_shift;
      // Count holds at 31, so clocks past 16 never reach the last-bit test
      if (bit_cnt != 5'h1F) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst || sup_rst) begin
      cfg <= `CFG_RESET;
    end else if (frame_done) begin
      cfg <= next_shift;
    end
  end

  wire mode_dc = cfg[`CFG_MODE_BIT];
  wire dir_c = cfg[`CFG_DIR_C_BIT];
  wire dir_a = cfg[`CFG_DIR_A_BIT];
  wire dir_b = cfg[`CFG_DIR_B_BIT];
  wire hs1_on = cfg[`CFG_HS1_BIT];
  wire hs2_on = cfg[`CFG_HS2_BIT];
  wire ls1_on = cfg[`CFG_LS1_BIT];
  wire ls2_on = cfg[`CFG_LS2_BIT];

  // 200 kHz tick from divider
  reg [5:0] osc_cnt;
  wire osc_tick = (osc_cnt == 6'h00);
  always @(posedge ref_clk) begin
    if (rst) begin
      osc_cnt <= 6'h00;
    end else if (osc_tick) begin
      osc_cnt <= OSC_RELOAD[5:0];
    end else begin
      osc_cnt <= osc_cnt - 6'h01;
    end
  end

  // Per-bridge overcurrent deglitch and off-timer
  wire bridge_disable = therm | sup_rst;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_oc
      reg [3:0] glitch_cnt;
      reg [7:0] off_cnt;
      reg trip;
      always @(posedge ref_clk) begin
        if (rst || bridge_disable) begin
          glitch_cnt <= 4'h0;
          off_cnt <= 8'h00;
          trip <= 1'b0;
        end else if (off_cnt != 8'h00) begin
          glitch_cnt <= 4'h0;
          if (osc_tick) begin
            off_cnt <= off_cnt - 8'h01;
          end
          trip <= (off_cnt != 8'h01) | ~osc_tick;
        end else if (!oc[gi]) begin
          glitch_cnt <= 4'h0;
          trip <= 1'b0;
        end else begin
          // Short qualifier sets the window floor, the next tick its ceiling
          if (glitch_cnt != GLITCH_LIMIT[3:0]) begin
            glitch_cnt <= glitch_cnt + 4'h1;
          end
          if (osc_tick && glitch_cnt == GLITCH_LIMIT[3:0]) begin
            off_cnt <= OFF_RELOAD[7:0];
            trip <= 1'b1;
          end
        end
      end
      assign bridge_tripped[gi] = trip;
    end
  endgenerate

  // Step dead time per phase
  reg [1:0] pwm_step_d;
  wire [1:0] dead_done;
  wire [1:0] pwm_step = {pwm_cb, pwm_ca};
  wire step_kill = over_v | sup_rst | therm | mode_dc;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_step
      reg [2:0] dead_cnt;
      always @(posedge ref_clk) begin
        if (rst) begin
          dead_cnt <= 3'h0;
        end else if (pwm_step[gi] != pwm_step_d[gi]) begin
          dead_cnt <= DEAD_RELOAD[2:0];
        end else if (dead_cnt != 3'h0) begin
          dead_cnt <= dead_cnt - 3'h1;
        end
      end
      assign dead_done[gi] = (dead_cnt == 3'h0);
    end
  endgenerate

  // Output stage
  wire en_a = ~therm & ~bridge_tripped[0];
  wire en_b = ~therm & ~bridge_tripped[1];
  wire en_c = ~therm & ~bridge_tripped[2];

  // Phase history for the dead-time counters and counterphase gate
  always @(posedge ref_clk) begin
    if (rst) begin
      pwm_step_d <= 2'h0;
    end else begin
      pwm_step_d <= pwm_step;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      dc_mode <= 1'b0;
    end else begin
      dc_mode <= mode_dc;
    end
  end

  // Direction is combinational on cfg, so reversal takes effect next edge
  always @(posedge ref_clk) begin
    if (rst) begin
      motor_a_bridge_high <= 2'h0;
      motor_a_bridge_low <= 2'h0;
    end else if (sup_rst) begin
      motor_a_bridge_high <= 2'h0;
      motor_a_bridge_low <= 2'h3;
    end else begin
      motor_a_bridge_high <= (pwm_a & en_a) ? {dir_a, ~dir_a} : 2'h0;
      motor_a_bridge_low <= en_a ? {~dir_a, dir_a} : 2'h0;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      motor_b_bridge_high <= 2'h0;
      motor_b_bridge_low <= 2'h0;
    end else if (sup_rst) begin
      motor_b_bridge_high <= 2'h0;
      motor_b_bridge_low <= 2'h3;
    end else begin
      motor_b_bridge_high <= (pwm_b & en_b) ? {dir_b, ~dir_b} : 2'h0;
      motor_b_bridge_low <= en_b ? {~dir_b, dir_b} : 2'h0;
    end
  end

  // Low sides of C stay off in step mode; the step stage owns them there
  always @(posedge ref_clk) begin
    if (rst) begin
      drive_c_out_first <= 1'b0;
      drive_c_out_second <= 1'b0;
      drive_c_low <= 2'h0;
    end else if (mode_dc) begin
      drive_c_out_first <= pwm_ca & en_c & ~dir_c & ~sup_rst;
      drive_c_out_second <= pwm_ca & en_c & dir_c & ~sup_rst;
      drive_c_low <= sup_rst ? 2'h3 : {ls2_on, ls1_on};
    end else begin
      drive_c_out_first <= hs1_on & ~therm & ~sup_rst;
      drive_c_out_second <= hs2_on & ~therm & ~sup_rst;
      drive_c_low <= 2'h0;
    end
  end

  // Phase on with PWM, counterphase after dead time when PWM low
  always @(posedge ref_clk) begin
    if (rst) begin
      step_phase_on <= 2'h0;
      step_counter_on <= 2'h0;
    end else if (step_kill) begin
      step_phase_on <= 2'h0;
      step_counter_on <= 2'h0;
    end else begin
      step_phase_on <= pwm_step;
      step_counter_on <= ~pwm_step & dead_done & ~pwm_step_d;
    end
  end
endmodule // motor_bridge_control

// [bridge_props.sv]
`timescale 1ns/10ps
module bridge_props (
  input wire ref_clk,
  input wire rst,
  input wire drive_a_pwm_in,
  input wire drive_b_pwm_in,
  input wire drive_c_pwm_b_in,
  input wire supply_over_20v,
  input wire thermal_shutdown_flag,
  input wire [2:0] overcurrent,
  input wire [1:0] motor_a_bridge_high,
  input wire [1:0] motor_a_bridge_low,
  input wire [1:0] motor_b_bridge_high,
  input wire [1:0] step_phase_on,
  input wire [1:0] step_counter_on,
  input wire [2:0] bridge_tripped
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_A_PWM: assert property (!$past(drive_a_pwm_in, 3) |-> motor_a_bridge_high == 2'h0)
    else $error("bridge A on without PWM");
  AST_B_PWM: assert property (!$past(drive_b_pwm_in, 3) |-> motor_b_bridge_high == 2'h0)
    else $error("bridge B on without PWM");
  AST_C_PHASE: assert property (!$past(drive_c_pwm_b_in, 3) |-> !step_phase_on[1])
    else $error("phase B on without PWM");
  AST_OVERVOLT: assert property (supply_over_20v [*5] |-> (step_phase_on | step_counter_on) == 2'h0)
    else $error("step output on above 20 V");
  AST_THERMAL: assert property (thermal_shutdown_flag [*5] |->
    (motor_a_bridge_high | motor_a_bridge_low | motor_b_bridge_high) == 2'h0)
    else $error("bridge on in thermal shutdown");
  AST_DEAD: assert property ($rose(step_counter_on[0]) |->
    !$past(step_phase_on[0]) && !$past(step_phase_on[0], 4))
    else $error("counterphase on before dead time");
  AST_NO_OVERLAP: assert property ((step_phase_on & step_counter_on) == 2'h0)
    else $error("phase and counterphase on together");
  AST_TRIP_CAUSE: assert property ($rose(bridge_tripped[0]) |-> $past(overcurrent[0], 3))
    else $error("trip without overcurrent");
  AST_TRIP_OFF: assert property (bridge_tripped[0] && $past(bridge_tripped[0]) |->
    motor_a_bridge_high == 2'h0)
    else $error("bridge A on while tripped");
  cover property ($rose(bridge_tripped[0]));
  cover property ($rose(step_counter_on[0]));
  cover property (thermal_shutdown_flag [*5]);
endmodule // bridge_props

// [host_model.sv]
`timescale 1ns/10ps
module host_model (
  input wire ref_clk,
  output reg drive_a_pwm_in,
  output reg drive_b_pwm_in,
  output reg drive_c_pwm_a_in,
  output reg drive_c_pwm_b_in,
  output reg ser_clk,
  output reg ser_enable_n,
  output reg ser_data_in
);
  // Idle: clock still, data low to avoid stray bits
  initial begin
    {drive_c_pwm_b_in, drive_c_pwm_a_in, drive_b_pwm_in, drive_a_pwm_in} = 4'h0;
    {ser_clk, ser_enable_n, ser_data_in} = 3'h2;
  end
  task pwm_set(input [3:0] m);
    {drive_c_pwm_b_in, drive_c_pwm_a_in, drive_b_pwm_in, drive_a_pwm_in} = m;
  endtask
  // Serial clock at ref_clk/8, slow enough for oversampling
  task send_frame(input [15:0] w);
    integer i;
    begin
      ser_enable_n = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        ser_data_in = w[i];
        repeat (4) @(posedge ref_clk);
        #1 ser_clk = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 ser_clk = 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      #1 {ser_enable_n, ser_data_in} = 2'h2;
    end
  endtask
endmodule // host_model

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  reg ref_clk = 1'b0;
  reg rst;
  reg supervisor_reset_n;
  reg thermal_shutdown_flag;
  reg supply_over_20v;
  reg [2:0] overcurrent;
  wire drive_a_pwm_in, drive_b_pwm_in, drive_c_pwm_a_in, drive_c_pwm_b_in;
  wire ser_clk, ser_enable_n, ser_data_in, drive_c_out_first, drive_c_out_second, dc_mode;
  wire [1:0] motor_a_bridge_high, motor_a_bridge_low, motor_b_bridge_high, motor_b_bridge_low;
  wire [1:0] drive_c_low, step_phase_on, step_counter_on;
  wire [2:0] bridge_tripped;
  integer num_errors = 0;
  integer checks = 0;
  integer seed = 32'h9e30c4a8;
  integer i, hi;
  reg [3:0] m;
  always #50 ref_clk = ~ref_clk;
  host_model host (.ref_clk, .drive_a_pwm_in, .drive_b_pwm_in, .drive_c_pwm_a_in,
    .drive_c_pwm_b_in, .ser_clk, .ser_enable_n, .ser_data_in);
  motor_bridge_control i_dut (.ref_clk, .rst, .drive_a_pwm_in, .drive_b_pwm_in,
    .drive_c_pwm_a_in, .drive_c_pwm_b_in, .ser_clk, .ser_enable_n, .ser_data_in,
    .supply_over_20v, .supervisor_reset_n, .thermal_shutdown_flag, .overcurrent,
    .motor_a_bridge_high, .motor_a_bridge_low, .motor_b_bridge_high, .motor_b_bridge_low,
    .drive_c_out_first, .drive_c_out_second, .drive_c_low, .step_phase_on,
    .step_counter_on, .bridge_tripped, .dc_mode);
  task cyc(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task check(input [1:0] seen, input [1:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    rst = 1'b1;
    supervisor_reset_n = 1'b1;
    thermal_shutdown_flag = 1'b0;
    supply_over_20v = 1'b0;
    overcurrent = 3'h0;
    cyc(20);
    rst = 1'b0;
    cyc(5);
    for (i = 0; i < 8; i = i + 1) begin
      m = $random(seed);
      hi = 20 + ($random(seed) & 127);
      host.pwm_set(m); // 250-cycle period, 40 kHz
      cyc(hi);
      check(|motor_a_bridge_high, m[0]);
      check(|motor_b_bridge_high, m[1]);
      check(step_phase_on[1], m[3]);
      host.pwm_set(4'h0);
      cyc(250 - hi);
      check(motor_a_bridge_high | motor_b_bridge_high, 2'h0);
    end
    supply_over_20v = 1'b1;
    host.pwm_set(4'hC);
    cyc(20);
    check(step_phase_on | step_counter_on, 2'h0);
    supply_over_20v = 1'b0;
    host.send_frame(16'h2000);
    cyc(10);
    check(dc_mode, 1'b0);
    host.send_frame(16'h2001);
    cyc(10);
    check(dc_mode, 1'b1);
    host.pwm_set(4'h4);
    cyc(10);
    check(drive_c_out_first ^ drive_c_out_second, 1'b1);
    supervisor_reset_n = 1'b0;
    cyc(10);
    check(dc_mode, 1'b0);
    check(motor_a_bridge_low, 2'h3);
    supervisor_reset_n = 1'b1;
    host.pwm_set(4'h3);
    thermal_shutdown_flag = 1'b1;
    cyc(10);
    check(motor_a_bridge_high, 2'h0);
    thermal_shutdown_flag = 1'b0;
    cyc(10);
    check(|motor_a_bridge_high, 1'b1);
    overcurrent = 3'h1;
    cyc(100);
    check(bridge_tripped[0], 1'b1);
    overcurrent = 3'h0;
    cyc(3000);
    check(motor_a_bridge_high, 2'h0);
    thermal_shutdown_flag = 1'b1;
    cyc(10);
    thermal_shutdown_flag = 1'b0;
    cyc(10);
    check(bridge_tripped[0], 1'b0);
    host.pwm_set(4'h7);
    host.send_frame(16'h3CC1);
    cyc(10);
    check(dc_mode, 1'b1);
    check(drive_c_low, 2'h3);
    check(motor_a_bridge_high, 2'h2);
    check({drive_c_out_first, drive_c_out_second}, 2'h1);
    host.send_frame(16'h0301);
    cyc(10);
    check({drive_c_out_first, drive_c_out_second}, 2'h3);
    check(drive_c_low, 2'h0);
    check(motor_a_bridge_high, 2'h1);
    m = $random(seed);
    overcurrent = {2'h3, m[0]};
    cyc(100);
    check(bridge_tripped[2:1], 2'h3);
    check(motor_b_bridge_high, 2'h0);
    overcurrent = 3'h0;
    give_verdict;
  end
  initial begin
    cyc(40000);
    num_errors = num_errors + 1;
    give_verdict;
  end
endmodule // tb_top
bind motor_bridge_control bridge_props i_props (.*);
